// [rtl/epa_pkg.sv]
// Purpose: Shared constants and carriers for the exception priority arbiter
// Assumes: 32-bit APB register bus, 12-bit byte address
// Notes:   Keys rank urgency; a smaller key is more urgent
package epa_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned KEY_W    = 4;
  localparam int unsigned PRI_W    = 3;
  localparam int unsigned SPLIT_W  = 2;
  localparam int unsigned SYS_EXC  = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned SLOTS    = 4;

  // Register byte offsets
  localparam logic [11:0] OFS_VTAB   = 12'h000;
  localparam logic [11:0] OFS_SPLIT  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PRI    = 12'h040;

  // Vector table layout
  localparam logic [31:0] VTAB_MASK     = 32'h3FFF_FF00;
  localparam logic [31:0] RESET_BASE    = 32'h0000_0000;
  localparam logic [31:0] SP_OFS        = 32'h0000_0000;
  localparam logic [31:0] RESET_VEC_OFS = 32'h0000_0004;
  localparam int unsigned VEC_SHIFT     = 2;

  // Reset values and field limits
  localparam logic [2:0]  PRI_RESET   = 3'h0;
  localparam logic [1:0]  SPLIT_RESET = 2'h0;
  localparam logic [2:0]  SPLIT_MAX   = 3'h3;
  localparam logic [2:0]  GRP_ALL     = 3'h7;

  // Fixed exceptions and their keys
  localparam int unsigned EXC_RESET = 1;
  localparam int unsigned EXC_NMI   = 2;
  localparam int unsigned EXC_HARD  = 3;
  localparam logic [3:0]  KEY_RESET = 4'h0;
  localparam logic [3:0]  KEY_NMI   = 4'h1;
  localparam logic [3:0]  KEY_HARD  = 4'h2;
  localparam logic [3:0]  KEY_CFG   = 4'h3;
  localparam logic [3:0]  KEY_NONE  = 4'hF;

  // System exceptions 0..15: which exist, which are configurable
  localparam logic [15:0] SYS_IMPL = 16'hD87E;
  localparam logic [15:0] SYS_CFG  = 16'hD870;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } epa_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } epa_apb_rsp_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } epa_bus_state_type;
endpackage : epa_pkg

// [rtl/epa_rank.sv]
// Purpose: Per-exception selection and preemption keys
// Assumes: Priorities stored three bits per exception
// Notes:   Purely combinational
`timescale 1ns/1ns
module epa_rank #(
  parameter int unsigned NUM_EXC = 48
) (
  input  wire logic [NUM_EXC*epa_pkg::PRI_W-1:0] pri_i,
  input  wire logic [epa_pkg::SPLIT_W-1:0]       split_i,
  output logic      [NUM_EXC*epa_pkg::KEY_W-1:0] sel_key_o,
  output logic      [NUM_EXC*epa_pkg::KEY_W-1:0] grp_key_o
);
  logic [epa_pkg::PRI_W-1:0] grp_mask;

  assign grp_mask = epa_pkg::GRP_ALL << split_i;

  for (genvar e = 0; e < NUM_EXC; e++)
  begin : g_key
    logic [epa_pkg::PRI_W-1:0] pri;
    assign pri = pri_i[e*epa_pkg::PRI_W +: epa_pkg::PRI_W];
    if (e == epa_pkg::EXC_RESET)
    begin : g_rst
      assign sel_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_RESET;
      assign grp_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_RESET;
    end
    else if (e == epa_pkg::EXC_NMI)
    begin : g_nmi
      assign sel_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_NMI;
      assign grp_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_NMI;
    end
    else if (e == epa_pkg::EXC_HARD)
    begin : g_hard
      assign sel_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_HARD;
      assign grp_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_HARD;
    end
    else
    begin : g_cfg
      assign sel_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] = epa_pkg::KEY_CFG + {1'b0, pri};
      assign grp_key_o[e*epa_pkg::KEY_W +: epa_pkg::KEY_W] =
        epa_pkg::KEY_CFG + {1'b0, pri & grp_mask};
    end
  end
endmodule : epa_rank

// [rtl/epa_select.sv]
// Purpose: Picks the most urgent pending exception
// Assumes: Keys already include the fixed ranks
// Notes:   Linear scan; fine for a few dozen sources
`timescale 1ns/1ns
module epa_select #(
  parameter int unsigned NUM_EXC = 48,
  parameter int unsigned NUM_W   = 6
) (
  input  wire logic [NUM_EXC-1:0]                pend_i,
  input  wire logic [NUM_EXC*epa_pkg::KEY_W-1:0] key_i,
  output logic                                   valid_o,
  output logic      [NUM_W-1:0]                  num_o,
  output logic      [epa_pkg::KEY_W-1:0]         key_o
);
  always_comb
  begin
    logic                      found;
    logic [NUM_W-1:0]          num;
    logic [epa_pkg::KEY_W-1:0] key;
    found = 1'b0;
    num   = '0;
    key   = epa_pkg::KEY_NONE;
    for (int i = 0; i < NUM_EXC; i++)
    begin
      // strict compare keeps lowest number on ties
      if (pend_i[i] && (!found || key_i[i*epa_pkg::KEY_W +: epa_pkg::KEY_W] < key))
      begin
        found = 1'b1;
        num   = NUM_W'(i);
        key   = key_i[i*epa_pkg::KEY_W +: epa_pkg::KEY_W];
      end
    end
    valid_o = found;
    num_o   = num;
    key_o   = key;
  end
endmodule : epa_select

// [rtl/epa_arbiter.sv]
// Purpose: Exception priority arbiter with relocatable vector table
// Assumes: Core supplies pending set, active number and mode each cycle
// Notes:   Decision and vector address are registered, one cycle late
//
// How it works
// - Word 0 of the table holds stack pointer, word 1 (byte 4) the reset handler
// - After reset the table base is zero whatever was programmed before
// - Software may relocate the base within 0x0000.0100 to 0x3FFF.FF00
// - Smaller priority value wins; all but three exceptions configurable
// - Every configurable priority resets to zero
// - Configurable priorities are three bits, values zero to seven
// - Reset, hard fault and NMI always outrank configurable exceptions
// - Equal priorities resolve to the smallest exception number
// - Strictly more urgent arrival preempts the running handler
// - Equal priority arrival never preempts, it simply stays pending
// - Priority splits at a set boundary into group and subpriority
// - Preemption compares group priority only
// - Pending pick uses group, then subpriority, then lowest number
// - Take only if priority sufficient and thread mode or outranking
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module epa_arbiter #(
  parameter int unsigned NUM_IRQ = 32,
  parameter int unsigned NUM_EXC = epa_pkg::SYS_EXC + NUM_IRQ,
  parameter int unsigned NUM_W   = $clog2(NUM_EXC)
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  input  wire epa_pkg::epa_apb_req_type  apb_req_i,
  output epa_pkg::epa_apb_rsp_type       apb_rsp_o,
  input  wire logic [NUM_EXC-1:0]        pend_i,
  input  wire logic [NUM_W-1:0]          active_num_i,
  input  wire logic                      thread_mode_i,
  input  wire logic                      mask_en_i,
  input  wire logic [epa_pkg::KEY_W-1:0] mask_key_i,
  output logic                           take_o,
  output logic                           preempt_o,
  output logic      [NUM_W-1:0]          sel_num_o,
  output logic      [31:0]               vec_addr_o,
  output logic      [31:0]               table_base_o
);
  localparam int unsigned PRI_WORDS = (NUM_EXC + epa_pkg::SLOTS - 1) / epa_pkg::SLOTS;
  localparam logic [NUM_EXC-1:0] IMPL = {{NUM_IRQ{1'b1}}, epa_pkg::SYS_IMPL};
  localparam logic [NUM_EXC-1:0] CFG  = {{NUM_IRQ{1'b1}}, epa_pkg::SYS_CFG};

  typedef struct packed {
    epa_pkg::epa_bus_state_type       bus;
    epa_pkg::epa_apb_rsp_type         rsp;
    logic [21:0]                      vector_base_offset;
    logic [epa_pkg::SPLIT_W-1:0]      split;
    logic [NUM_EXC*epa_pkg::PRI_W-1:0] pri;
    logic                             take;
    logic                             preempt;
    logic [NUM_W-1:0]                 sel_num;
    logic [31:0]                      vec_addr;
    logic [31:0]                      base;
  } epa_state_type;

  epa_state_type                    st;
  epa_state_type                    next_st;
  logic [NUM_EXC*epa_pkg::KEY_W-1:0] sel_keys;
  logic [NUM_EXC*epa_pkg::KEY_W-1:0] grp_keys;
  logic [NUM_EXC-1:0]               eff_pend;
  logic                             sel_valid;
  logic [NUM_W-1:0]                 sel_num;
  logic [epa_pkg::KEY_W-1:0]        sel_key;
  logic [epa_pkg::KEY_W-1:0]        sel_grp;
  logic [epa_pkg::KEY_W-1:0]        act_grp;
  logic                             sufficient;
  logic                             outranks;
  logic                             take;
  logic [31:0]                      base;
  logic [11:0]                      pri_ofs;
  logic [9:0]                       pri_idx;
  logic                             pri_hit;

  epa_rank #(
    .NUM_EXC (NUM_EXC)
  ) u_rank (
    .pri_i     (st.pri),
    .split_i   (st.split),
    .sel_key_o (sel_keys),
    .grp_key_o (grp_keys)
  );

  // Reserved slots can never win, whatever the core drives
  assign eff_pend = pend_i & IMPL;

  // full key orders group then sub
  epa_select #(
    .NUM_EXC (NUM_EXC),
    .NUM_W   (NUM_W)
  ) u_select (
    .pend_i  (eff_pend),
    .key_i   (sel_keys),
    .valid_o (sel_valid),
    .num_o   (sel_num),
    .key_o   (sel_key)
  );

  assign sel_grp = grp_keys[sel_num*epa_pkg::KEY_W +: epa_pkg::KEY_W];
  assign act_grp = grp_keys[active_num_i*epa_pkg::KEY_W +: epa_pkg::KEY_W];

  assign sufficient = !mask_en_i || (sel_key < mask_key_i);
  assign outranks   = sel_grp < act_grp;
  assign take       = sel_valid && sufficient && (thread_mode_i || outranks);

  // low byte and top bits forced to zero
  assign base = {2'h0, st.vector_base_offset, 8'h00} & epa_pkg::VTAB_MASK;

  assign pri_ofs = apb_req_i.paddr - epa_pkg::OFS_PRI;
  assign pri_idx = pri_ofs[11:2];
  assign pri_hit = (apb_req_i.paddr >= epa_pkg::OFS_PRI) && (pri_idx < 10'(PRI_WORDS));

  always_comb
  begin
    logic [31:0] rdata;
    logic        hit;
    logic        wr;
    next_st = st;
    rdata   = '0;
    hit     = 1'b1;
    wr      = (st.bus == epa_pkg::BUS_WAIT) && apb_req_i.pwrite;
    if (pri_hit)
    begin
      for (int e = 0; e < NUM_EXC; e++)
      begin
        if (CFG[e] && (10'(e / epa_pkg::SLOTS) == pri_idx))
        begin
          rdata[(e % epa_pkg::SLOTS)*epa_pkg::BYTE_W +: epa_pkg::PRI_W] =
            st.pri[e*epa_pkg::PRI_W +: epa_pkg::PRI_W];
          if (wr)
            next_st.pri[e*epa_pkg::PRI_W +: epa_pkg::PRI_W] =
              apb_req_i.pwdata[(e % epa_pkg::SLOTS)*epa_pkg::BYTE_W +: epa_pkg::PRI_W];
        end
      end
    end
    else
    begin
      case (apb_req_i.paddr)
        epa_pkg::OFS_VTAB:
        begin
          rdata = base;
          if (wr)
            next_st.vector_base_offset = apb_req_i.pwdata[29:8];
        end
        epa_pkg::OFS_SPLIT:
        begin
          rdata[epa_pkg::SPLIT_W-1:0] = st.split;
          // Values 4 to 7 in bits 2:0 clamp to all-sub; higher bits are ignored
          if (wr)
            next_st.split = (apb_req_i.pwdata[2:0] > epa_pkg::SPLIT_MAX) ?
              epa_pkg::SPLIT_MAX[1:0] : apb_req_i.pwdata[1:0];
        end
        epa_pkg::OFS_STATUS:
        begin
          rdata[NUM_W-1:0] = st.sel_num;
          rdata[16]        = st.take;
          rdata[17]        = st.preempt;
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
    end

    // Two wait states give a registered answer
    case (st.bus)
      epa_pkg::BUS_IDLE:
      begin
        next_st.rsp = '0;
        if (apb_req_i.psel && apb_req_i.penable)
          next_st.bus = epa_pkg::BUS_WAIT;
      end
      epa_pkg::BUS_WAIT:
      begin
        next_st.bus         = epa_pkg::BUS_DONE;
        next_st.rsp.pready  = 1'b1;
        next_st.rsp.pslverr = !hit;
        next_st.rsp.prdata  = (hit && !apb_req_i.pwrite) ? rdata : '0;
      end
      epa_pkg::BUS_DONE:
      begin
        next_st.bus = epa_pkg::BUS_IDLE;
        next_st.rsp = '0;
      end
      default:
      begin
        next_st.bus = epa_pkg::BUS_IDLE;
        next_st.rsp = '0;
      end
    endcase

    next_st.take     = take;
    next_st.preempt  = take && !thread_mode_i;
    next_st.sel_num  = sel_num;
    next_st.base     = base;
    // entry n sits at base plus four n
    next_st.vec_addr = base + (32'(sel_num) << epa_pkg::VEC_SHIFT);

    if (srst_i)
    begin
      // base returns to zero, priorities to zero
      next_st.bus                = epa_pkg::BUS_IDLE;
      next_st.rsp                = '0;
      next_st.vector_base_offset = '0;
      next_st.split              = epa_pkg::SPLIT_RESET;
      next_st.pri                = {NUM_EXC{epa_pkg::PRI_RESET}};
      next_st.take               = 1'b0;
      next_st.preempt            = 1'b0;
      next_st.sel_num            = '0;
      next_st.vec_addr           = epa_pkg::RESET_BASE;
      next_st.base               = epa_pkg::RESET_BASE;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    st <= next_st;
  end

  assign apb_rsp_o    = st.rsp;
  assign take_o       = st.take;
  assign preempt_o    = st.preempt;
  assign sel_num_o    = st.sel_num;
  assign vec_addr_o   = st.vec_addr;
  assign table_base_o = st.base;

  // Helpers: a pending source below the winner with a better or tied key, and any pending source with a strictly better key
  logic beaten;
  logic better;
  always_comb
  begin
    beaten = 1'b0;
    better = 1'b0;
    for (int j = 0; j < NUM_EXC; j++)
    begin
      if (eff_pend[j] && (NUM_W'(j) < sel_num) &&
          (sel_keys[j*epa_pkg::KEY_W +: epa_pkg::KEY_W] <= sel_key))
        beaten = 1'b1;
      if (eff_pend[j] && (sel_keys[j*epa_pkg::KEY_W +: epa_pkg::KEY_W] < sel_key))
        better = 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  base_reset_a: assert property ($fell(srst_i) |-> table_base_o == epa_pkg::RESET_BASE)
    else $error("table base not zero after reset");
  pri_reset_a: assert property ($fell(srst_i) |-> st.pri == '0)
    else $error("priorities not zero after reset");
  base_align_a: assert property ((table_base_o & ~epa_pkg::VTAB_MASK) == '0)
    else $error("table base outside aligned range");
  vec_reset_a: assert property (eff_pend[epa_pkg::EXC_RESET] |=>
    sel_num_o == NUM_W'(epa_pkg::EXC_RESET) &&
    vec_addr_o == table_base_o + epa_pkg::RESET_VEC_OFS)
    else $error("reset vector not at base plus four");
  fixed_wins_a: assert property (eff_pend[epa_pkg::EXC_NMI] &&
    !eff_pend[epa_pkg::EXC_RESET] |-> sel_num == NUM_W'(epa_pkg::EXC_NMI))
    else $error("nmi outranked by configurable source");
  tie_order_a: assert property (sel_valid |-> !beaten)
    else $error("winner not lowest number among best");
  no_equal_a: assert property (sel_valid && !thread_mode_i &&
    sel_grp >= act_grp |=> !preempt_o)
    else $error("preempt without strictly higher group");
  preempt_ok_a: assert property (sel_valid && sufficient && !thread_mode_i &&
    sel_grp < act_grp |=> preempt_o && take_o)
    else $error("higher group did not preempt");
  take_gate_a: assert property (take_o |-> $past(sufficient))
    else $error("taken without sufficient priority");
  pready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("pready held longer than one cycle");

  best_key_a: assert property (sel_valid |-> !better)
    else $error("winner key beaten by a pending source");
  idle_take_a: assert property (!sel_valid |=>
    !take_o && sel_num_o == '0)
    else $error("take or number without pending source");
  thread_take_a: assert property (sel_valid && sufficient && thread_mode_i |=>
    take_o && !preempt_o)
    else $error("thread mode did not take without preempt");
  mask_block_a: assert property (sel_valid && !sufficient |=> !take_o)
    else $error("taken despite priority limit");
  vec_sum_a: assert property (
    vec_addr_o == table_base_o + (32'(sel_num_o) << epa_pkg::VEC_SHIFT))
    else $error("vector address not base plus four n");
  base_write_a: assert property (st.bus == epa_pkg::BUS_WAIT && apb_req_i.pwrite &&
    apb_req_i.paddr == epa_pkg::OFS_VTAB |->
    ##2 table_base_o == ($past(apb_req_i.pwdata, 2) & epa_pkg::VTAB_MASK))
    else $error("relocated base not applied");
  preempt_take_a: assert property (preempt_o |-> take_o)
    else $error("preempt without take");
endmodule : epa_arbiter

// [verification/epa_core_model.sv]
// Purpose: Core-side vector fetch model for the arbiter bench
// Assumes: Table words follow the software layout for handlers
// Notes:   One-cycle fetch; a real bus could stall longer
`timescale 1ns/1ns
module epa_core_model #(
  parameter logic [31:0] SP_INIT = 32'h2000_0400
) (
  input  wire logic        sys_clk_i,
  input  wire logic        take_i,
  input  wire logic [31:0] vec_addr_i,
  input  wire logic [31:0] base_i,
  output logic      [31:0] handler_o
);
  logic [31:0] ofs;

  assign ofs = vec_addr_i - base_i;
  initial handler_o = 32'h0000_0000;

  always @(posedge sys_clk_i)
  begin
    if (take_i)
    begin
      handler_o <= (ofs == 32'h0000_0000) ? SP_INIT : (32'h0000_2000 + (ofs << 2)) | 32'h0000_0001;
    end
    else
    begin
      // Idle fetch bus inverts every bit of the last word each cycle
      handler_o <= ~handler_o;
    end
  end
endmodule : epa_core_model

// [verification/exception_priority_arbiter_bench.sv]
// Purpose: Self-checking bench for the exception priority arbiter
// Assumes: APB answers by pready; decisions lag inputs by one edge
// Notes:   Random priorities, splits and pending sets plus fixed corners
`timescale 1ns/1ns
module exception_priority_arbiter_bench;
  logic                     clk  = 1'b0;
  logic                     srst = 1'b1;
  epa_pkg::epa_apb_req_type req  = '0;
  epa_pkg::epa_apb_rsp_type rsp;
  logic [47:0]              pend = '0;
  logic [5:0]               act  = '0;
  logic                     thr  = 1'b1;
  logic                     men  = 1'b0;
  logic [3:0]               mkey = 4'hF;
  logic                     take;
  logic                     preempt;
  logic [5:0]               sel;
  logic [31:0]              vec;
  logic [31:0]              base;
  logic [31:0]              handler;
  logic [31:0]              rd;
  logic [31:0]              vbase;
  logic                     err;
  logic [2:0]               pr [48];
  logic [1:0]               spl;
  int                       fails   = 0;
  int                       checked = 0;

  always #50 clk = ~clk;

  epa_arbiter u_dut (
    .sys_clk_i(clk), .srst_i(srst), .apb_req_i(req), .apb_rsp_o(rsp),
    .pend_i(pend), .active_num_i(act), .thread_mode_i(thr), .mask_en_i(men),
    .mask_key_i(mkey), .take_o(take), .preempt_o(preempt), .sel_num_o(sel),
    .vec_addr_o(vec), .table_base_o(base)
  );

  epa_core_model u_core (
    .sys_clk_i(clk), .take_i(take), .vec_addr_i(vec), .base_i(base), .handler_o(handler)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait
    do
      @(posedge clk);
    while (rsp.pready !== 1'b1);
    chk({31'h0, rsp.pready}, 32'h1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rchk

  function automatic logic live(input int n);
    return n >= 16 || epa_pkg::SYS_IMPL[n];
  endfunction : live

  function automatic logic [3:0] key_of(input int n, input logic grp);
    logic [2:0] p;
    p = grp ? (pr[n] & (3'h7 << spl)) : pr[n];
    if (n >= 1 && n <= 3)
      return 4'(n - 1);
    return epa_pkg::KEY_CFG + {1'b0, p};
  endfunction : key_of

  task automatic arb(input logic [47:0] p, input logic t, input logic [5:0] a,
                     input logic me, input logic [3:0] mk);
    int   w;
    logic [3:0] wk;
    logic hit;
    logic tk;
    w   = 0;
    wk  = 4'hF;
    hit = 1'b0;
    for (int n = 47; n >= 0; n--)
      if (p[n] && live(n) && key_of(n, 1'b0) <= wk)
      begin
        w   = n;
        wk  = key_of(n, 1'b0);
        hit = 1'b1;
      end
    tk = hit && (!me || wk < mk) && (t || key_of(w, 1'b1) < key_of(a, 1'b1));
    pend <= p;
    thr  <= t;
    act  <= a;
    men  <= me;
    mkey <= mk;
    repeat (2) @(posedge clk);
    chk({31'h0, take}, {31'h0, tk});
    chk({31'h0, preempt}, {31'h0, tk & ~t});
    chk({26'h0, sel}, 32'(w));
    chk(vec, vbase + 32'(w) * 32'd4);
    @(posedge clk);
    if (tk)
      chk(handler, 32'h0000_2000 + 32'(w) * 32'd16 + 32'h1);
    rchk(epa_pkg::OFS_STATUS, {14'h0, tk & ~t, tk, 10'h0, 6'(w)});
  endtask : arb

  task automatic load_pri();
    logic [31:0] d;
    for (int k = 0; k < 12; k++)
    begin
      d = $urandom & 32'h0707_0707;
      apb(1'b1, epa_pkg::OFS_PRI + 12'(4 * k), d);
      for (int b = 0; b < 4; b++)
        pr[4 * k + b] = (live(4 * k + b) && (4 * k + b >= 16 || epa_pkg::SYS_CFG[4 * k + b]))
                        ? d[8 * b +: 3] : 3'h0;
      rchk(epa_pkg::OFS_PRI + 12'(4 * k), {5'h0, pr[4 * k + 3], 5'h0, pr[4 * k + 2],
           5'h0, pr[4 * k + 1], 5'h0, pr[4 * k]});
    end
  endtask : load_pri

  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] edge_base [3];
    logic [5:0]  a;
    d = $urandom(79632);
    for (int n = 0; n < 48; n++)
      pr[n] = 3'h0;
    spl   = 2'h0;
    vbase = 32'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(base, 32'h0);
    rchk(epa_pkg::OFS_VTAB, 32'h0);
    rchk(epa_pkg::OFS_SPLIT, 32'h0);
    for (int k = 0; k < 12; k++)
      rchk(epa_pkg::OFS_PRI + 12'(4 * k), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Corners with every priority at its default
    arb(48'h0000_0003_0000, 1'b1, 6'd0, 1'b0, 4'hF);
    arb(48'h0000_0001_000E, 1'b1, 6'd0, 1'b0, 4'hF);
    arb(48'h0000_0002_0000, 1'b0, 6'd16, 1'b0, 4'hF);
    arb(48'h0000_0000_0008, 1'b0, 6'd16, 1'b0, 4'hF);
    arb(48'h0000_0001_0000, 1'b1, 6'd0, 1'b1, 4'h3);
    edge_base[0] = 32'hFFFF_FFFF;
    edge_base[1] = 32'h0000_0100;
    edge_base[2] = ($urandom & 32'h3FFF_FF00) | 32'h0000_0100;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, epa_pkg::OFS_VTAB, edge_base[i]);
      vbase = edge_base[i] & epa_pkg::VTAB_MASK;
      rchk(epa_pkg::OFS_VTAB, vbase);
      chk(base, vbase);
    end
    for (int i = 0; i < 200; i++)
    begin
      if (i % 25 == 0)
      begin
        load_pri();
        d = $urandom_range(7);
        apb(1'b1, epa_pkg::OFS_SPLIT, d);
        spl = (d > 3) ? 2'h3 : d[1:0];
        rchk(epa_pkg::OFS_SPLIT, {30'h0, spl});
      end
      do
        a = 6'($urandom_range(47, 1));
      while (!live(a));
      arb(48'({$urandom, $urandom}) & 48'({$urandom, $urandom}), 1'($urandom), a,
          1'($urandom), 4'($urandom));
    end
    // Second reset drops the relocation
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    vbase = 32'h0;
    spl   = 2'h0;
    for (int n = 0; n < 48; n++)
      pr[n] = 3'h0;
    chk(base, 32'h0);
    rchk(epa_pkg::OFS_PRI + 12'h010, 32'h0);
    arb(48'h0000_0010_0000, 1'b1, 6'd0, 1'b0, 4'hF);
    print_verdict();
  end
endmodule : exception_priority_arbiter_bench
